// File: rtl/brpc_port_in.v
`timescale 1ns/1ps
`default_nettype none
`include "brpc_regs.vh"

module brpc_port_in (
    input  wire                         clk,
    input  wire                         sys_rst,
    input  wire                         chip_wide_clear_n,
    input  wire                         aclr,
    input  wire                         in_ce,
    input  wire                         hold,
    input  wire [`BRPC_ADDR_W-1:0]      addr,
    input  wire [`BRPC_WORD_W-1:0]      din,
    input  wire [`BRPC_LANES-1:0]       lane_mask,
    input  wire                         wren,
    input  wire                         rden,
    output reg  [`BRPC_ADDR_W-1:0]      addr_q,
    output reg  [`BRPC_WORD_W-1:0]      din_q,
    output reg  [`BRPC_LANES-1:0]       mask_q,
    output reg                          wren_q,
    output reg                          rden_q
);

    // ======================================================================
    // Address register
    // Address clear path
    always @(posedge clk or posedge aclr or negedge chip_wide_clear_n) begin
        if (!chip_wide_clear_n) begin
            addr_q <= `BRPC_RST_ADDR;
        end else if (aclr) begin
            addr_q <= `BRPC_RST_ADDR;
        end else if (sys_rst) begin
            addr_q <= `BRPC_RST_ADDR;
        end else if (in_ce) begin
            addr_q <= hold ? addr_q : addr;
        end
    end

    // ======================================================================
    // Data and strobe registers, no port clear
    // Registered control inputs
    always @(posedge clk or negedge chip_wide_clear_n) begin
        if (!chip_wide_clear_n) begin
            din_q  <= `BRPC_RST_WORD;
            wren_q <= 1'b0;
            rden_q <= 1'b0;
        end else if (sys_rst) begin
            din_q  <= `BRPC_RST_WORD;
            wren_q <= 1'b0;
            rden_q <= 1'b0;
        end else if (in_ce) begin
            din_q  <= din;
            wren_q <= wren;
            rden_q <= rden;
        end
    end

    // ======================================================================
    // Lane mask register
    // No clear input
    always @(posedge clk) begin
        if (sys_rst) begin
            mask_q <= `BRPC_RST_MASK;
        end else if (in_ce) begin
            mask_q <= lane_mask;
        end
    end

endmodule
`default_nettype wire

// File: rtl/brpc_port_out.v
`timescale 1ns/1ps
`default_nettype none
`include "brpc_regs.vh"

module brpc_port_out (
    input  wire                         clk,
    input  wire                         sys_rst,
    input  wire                         chip_wide_clear_n,
    input  wire                         aclr,
    input  wire                         out_ce,
    input  wire                         rd_now,
    input  wire                         oreg_en,
    input  wire [`BRPC_WORD_W-1:0]      rd_data,
    output reg  [`BRPC_WORD_W-1:0]      dout_q
);

    reg [`BRPC_WORD_W-1:0] latch_q;

    // ======================================================================
    // Output latch: captures only on an active read
    // Immediate clear
    always @(posedge clk or posedge aclr or negedge chip_wide_clear_n) begin
        if (!chip_wide_clear_n) begin
            latch_q <= `BRPC_RST_WORD;
        end else if (aclr) begin
            latch_q <= `BRPC_RST_WORD;
        end else if (sys_rst) begin
            latch_q <= `BRPC_RST_WORD;
        end else if (rd_now) begin
            latch_q <= rd_data;
        end
    end

    // ======================================================================
    // Output stage: flow-through copy or extra register
    // Port clear reaches output
    always @(posedge clk or posedge aclr or negedge chip_wide_clear_n) begin
        if (!chip_wide_clear_n) begin
            dout_q <= `BRPC_RST_WORD;
        end else if (aclr) begin
            dout_q <= `BRPC_RST_WORD;
        end else if (sys_rst) begin
            dout_q <= `BRPC_RST_WORD;
        end else if (oreg_en) begin
            if (out_ce) begin
                dout_q <= latch_q;
            end
        end else if (rd_now) begin
            dout_q <= rd_data;
        end
    end

endmodule
`default_nettype wire

// File: rtl/brpc_top.v
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "brpc_regs.vh"

module brpc_top (
    input  wire                         clk,
    input  wire                         sys_rst,
    input  wire                         chip_wide_clear_n,
    input  wire [1:0]                   cfg_width_a,
    input  wire [1:0]                   cfg_width_b,
    input  wire                         cfg_packed,
    input  wire                         cfg_new_data,
    input  wire                         cfg_oreg_a,
    input  wire                         cfg_oreg_b,
    input  wire                         a_in_ce,
    input  wire                         a_out_ce,
    input  wire                         a_aclr,
    input  wire                         a_hold,
    input  wire [`BRPC_ADDR_W-1:0]      a_addr,
    input  wire [`BRPC_WORD_W-1:0]      a_din,
    input  wire [`BRPC_LANES-1:0]       a_lane_mask,
    input  wire                         a_wren,
    input  wire                         a_rden,
    output wire [`BRPC_WORD_W-1:0]      a_dout,
    input  wire                         b_in_ce,
    input  wire                         b_out_ce,
    input  wire                         b_aclr,
    input  wire                         b_hold,
    input  wire [`BRPC_ADDR_W-1:0]      b_addr,
    input  wire [`BRPC_WORD_W-1:0]      b_din,
    input  wire [`BRPC_LANES-1:0]       b_lane_mask,
    input  wire                         b_wren,
    input  wire                         b_rden,
    output wire [`BRPC_WORD_W-1:0]      b_dout
);

    // ======================================================================
    // Configuration, registered so a change lands on a clean edge
    reg [1:0] width_a_q;
    reg [1:0] width_b_q;
    reg       packed_q;
    reg       new_data_q;
    reg       oreg_a_q;
    reg       oreg_b_q;

    always @(posedge clk or negedge chip_wide_clear_n) begin
        if (!chip_wide_clear_n) begin
            width_a_q  <= `BRPC_RST_WIDTH;
            width_b_q  <= `BRPC_RST_WIDTH;
            packed_q   <= `BRPC_RST_PACKED;
            new_data_q <= `BRPC_RST_NEWDATA;
            oreg_a_q   <= `BRPC_RST_OREG;
            oreg_b_q   <= `BRPC_RST_OREG;
        end else if (sys_rst) begin
            width_a_q  <= `BRPC_RST_WIDTH;
            width_b_q  <= `BRPC_RST_WIDTH;
            packed_q   <= `BRPC_RST_PACKED;
            new_data_q <= `BRPC_RST_NEWDATA;
            oreg_a_q   <= `BRPC_RST_OREG;
            oreg_b_q   <= `BRPC_RST_OREG;
        end else begin
            width_a_q  <= cfg_width_a;
            width_b_q  <= cfg_width_b;
            packed_q   <= cfg_packed;
            new_data_q <= cfg_new_data;
            oreg_a_q   <= cfg_oreg_a;
            oreg_b_q   <= cfg_oreg_b;
        end
    end

    // ======================================================================
    // Address and lane mapping
    function [`BRPC_IDX_W-1:0] word_idx;
        input [1:0]              w;
        input                    pk;
        input                    side;
        input [`BRPC_ADDR_W-1:0] ad;
        begin
            case (w)
                `BRPC_W36: word_idx = ad[7:0];
                `BRPC_W18: word_idx = ad[8:1];
                default:   word_idx = ad[9:2];
            endcase
            if (pk) begin
                word_idx[`BRPC_PACK_BIT] = side;
            end
        end
    endfunction

    function [`BRPC_LANES-1:0] lane_sel;
        input [1:0]              w;
        input [`BRPC_ADDR_W-1:0] ad;
        begin
            case (w)
                `BRPC_W36: lane_sel = 4'hf;
                `BRPC_W18: lane_sel = ad[0] ? 4'hc : 4'h3;
                default:   lane_sel = 4'h1 << ad[1:0];
            endcase
        end
    endfunction

    function [`BRPC_LANES-1:0] mask_map;
        input [1:0]              w;
        input [`BRPC_ADDR_W-1:0] ad;
        input [`BRPC_LANES-1:0]  m;
        begin
            case (w)
                `BRPC_W36: mask_map = m;
                `BRPC_W18: mask_map = ad[0] ? {m[1:0], 2'h0}
                                            : {2'h0, m[1:0]};
                default:   mask_map = 4'hf;
            endcase
        end
    endfunction

    function [`BRPC_WORD_W-1:0] place;
        input [1:0]              w;
        input [`BRPC_WORD_W-1:0] d;
        begin
            case (w)
                `BRPC_W36: place = d;
                `BRPC_W18: place = {d[17:0], d[17:0]};
                default:   place = {4{d[8:0]}};
            endcase
        end
    endfunction

    function [`BRPC_WORD_W-1:0] extract;
        input [1:0]              w;
        input [`BRPC_ADDR_W-1:0] ad;
        input [`BRPC_WORD_W-1:0] wd;
        begin
            case (w)
                `BRPC_W36: extract = wd;
                `BRPC_W18: extract = {18'h0_0000,
                                      ad[0] ? wd[35:18] : wd[17:0]};
                default:   extract = {27'h000_0000,
                                      wd[ad[1:0]*`BRPC_LANE_W +: 9]};
            endcase
        end
    endfunction

    // Lanes selected take new data, the rest keep old
    function [`BRPC_WORD_W-1:0] merge;
        input [`BRPC_LANES-1:0]  ln;
        input [`BRPC_WORD_W-1:0] nw;
        input [`BRPC_WORD_W-1:0] od;
        integer k;
        begin
            merge = od;
            for (k = 0; k < `BRPC_LANES; k = k + 1) begin
                if (ln[k]) begin
                    merge[k*`BRPC_LANE_W +: 9] = nw[k*`BRPC_LANE_W +: 9];
                end
            end
        end
    endfunction

    // ======================================================================
    // Input stages
    wire [`BRPC_ADDR_W-1:0] a_addr_q;
    wire [`BRPC_WORD_W-1:0] a_din_q;
    wire [`BRPC_LANES-1:0]  a_mask_q;
    wire                    a_wren_q;
    wire                    a_rden_q;
    wire [`BRPC_ADDR_W-1:0] b_addr_q;
    wire [`BRPC_WORD_W-1:0] b_din_q;
    wire [`BRPC_LANES-1:0]  b_mask_q;
    wire                    b_wren_q;
    wire                    b_rden_q;

    brpc_port_in u_in_a (
        .clk               (clk),
        .sys_rst           (sys_rst),
        .chip_wide_clear_n (chip_wide_clear_n),
        .aclr              (a_aclr),
        .in_ce             (a_in_ce),
        .hold              (a_hold),
        .addr              (a_addr),
        .din               (a_din),
        .lane_mask         (a_lane_mask),
        .wren              (a_wren),
        .rden              (a_rden),
        .addr_q            (a_addr_q),
        .din_q             (a_din_q),
        .mask_q            (a_mask_q),
        .wren_q            (a_wren_q),
        .rden_q            (a_rden_q)
    );

    brpc_port_in u_in_b (
        .clk               (clk),
        .sys_rst           (sys_rst),
        .chip_wide_clear_n (chip_wide_clear_n),
        .aclr              (b_aclr),
        .in_ce             (b_in_ce),
        .hold              (b_hold),
        .addr              (b_addr),
        .din               (b_din),
        .lane_mask         (b_lane_mask),
        .wren              (b_wren),
        .rden              (b_rden),
        .addr_q            (b_addr_q),
        .din_q             (b_din_q),
        .mask_q            (b_mask_q),
        .wren_q            (b_wren_q),
        .rden_q            (b_rden_q)
    );

    // ======================================================================
    // Array access, one clock after the registered address
    // Packed halves stay single-port, at most 18 bits wide
    wire [1:0] eff_w_a = (packed_q && width_a_q == `BRPC_W36)
                         ? `BRPC_W18 : width_a_q;
    wire [1:0] eff_w_b = (packed_q && width_b_q == `BRPC_W36)
                         ? `BRPC_W18 : width_b_q;

    wire [`BRPC_IDX_W-1:0]  a_idx = word_idx(eff_w_a, packed_q, 1'b0,
                                             a_addr_q);
    wire [`BRPC_IDX_W-1:0]  b_idx = word_idx(eff_w_b, packed_q, 1'b1,
                                             b_addr_q);

    wire [`BRPC_LANES-1:0]  a_lanes = lane_sel(eff_w_a, a_addr_q)
                                    & mask_map(eff_w_a, a_addr_q, a_mask_q);
    wire [`BRPC_LANES-1:0]  b_lanes = lane_sel(eff_w_b, b_addr_q)
                                    & mask_map(eff_w_b, b_addr_q, b_mask_q);
    wire [`BRPC_WORD_W-1:0] a_wdata = place(eff_w_a, a_din_q);
    wire [`BRPC_WORD_W-1:0] b_wdata = place(eff_w_b, b_din_q);

    wire a_wr = a_in_ce && a_wren_q;
    wire b_wr = b_in_ce && b_wren_q;
    wire a_rd = a_in_ce && a_rden_q;
    wire b_rd = b_in_ce && b_rden_q;

    reg [`BRPC_WORD_W-1:0] mem [0:`BRPC_DEPTH-1];
    integer i;

    // Both ports write together
    // Same lane written by both: port A lands last and wins
    always @(posedge clk) begin
        for (i = 0; i < `BRPC_LANES; i = i + 1) begin
            if (b_wr && b_lanes[i]) begin
                mem[b_idx][i*`BRPC_LANE_W+:9] <= b_wdata[i*`BRPC_LANE_W+:9];
            end
            if (a_wr && a_lanes[i]) begin
                mem[a_idx][i*`BRPC_LANE_W+:9] <= a_wdata[i*`BRPC_LANE_W+:9];
            end
        end
    end

    // ======================================================================
    // Read words; a write from the other port reads as old data
    // One clock, known collision data
    wire [`BRPC_WORD_W-1:0] a_old = mem[a_idx];
    wire [`BRPC_WORD_W-1:0] b_old = mem[b_idx];

    wire [`BRPC_WORD_W-1:0] a_word = (new_data_q && a_wr)
                                   ? merge(a_lanes, a_wdata, a_old) : a_old;
    wire [`BRPC_WORD_W-1:0] b_word = (new_data_q && b_wr)
                                   ? merge(b_lanes, b_wdata, b_old) : b_old;

    wire [`BRPC_WORD_W-1:0] a_rdata = extract(eff_w_a, a_addr_q, a_word);
    wire [`BRPC_WORD_W-1:0] b_rdata = extract(eff_w_b, b_addr_q, b_word);

    // ======================================================================
    // Output stages
    // Latency set per port
    brpc_port_out u_out_a (
        .clk               (clk),
        .sys_rst           (sys_rst),
        .chip_wide_clear_n (chip_wide_clear_n),
        .aclr              (a_aclr),
        .out_ce            (a_out_ce),
        .rd_now            (a_rd),
        .oreg_en           (oreg_a_q),
        .rd_data           (a_rdata),
        .dout_q            (a_dout)
    );

    brpc_port_out u_out_b (
        .clk               (clk),
        .sys_rst           (sys_rst),
        .chip_wide_clear_n (chip_wide_clear_n),
        .aclr              (b_aclr),
        .out_ce            (b_out_ce),
        .rd_now            (b_rd),
        .oreg_en           (oreg_b_q),
        .rd_data           (b_rdata),
        .dout_q            (b_dout)
    );

endmodule
`default_nettype wire

// File: shared/brpc_regs.vh
// Operation
// - Array holds 8,192 data bits, 9,216 counting the spare bit per byte.
// - Clock enable low: gated registers hold, no read or write happens.
// - Each port has its own read strobe and write strobe.
// - Spare bit per byte stored and returned like data; no parity computed.
// - Write with read strobe low keeps the last read output.
// - Same-address read during write returns new or old data per setting.
// - Only lanes with mask bit set are written; others keep contents.
// - Unused lane mask defaults to all ones; write strobe alone decides.
// - Lane masking only in 16/18 and 32/36 bit write widths.
// - Mask bits 0..3 select lanes 8:0, 17:9, 26:18, 35:27; any combination.
// - Mask bits active high; LSB governs least significant lane.
// - Lane mask registers have no clear and ignore asynchronous clear.
// - During write, masked lanes read old; unmasked lanes new or old.
// - Packed use: two single-port halves, each at most 18 bits, one clock.
// - Address hold high: address register reloads its own value.
// - Each port has its own address hold, default low.
// - Async clear hits only read address, output registers and latches.
// - Power-up resets all; chip-wide clear all but lane masks; port clear address and output.
// - True dual-port: two reads, two writes, or read plus write.
// - Each port takes two separate clock enables.
// - All address, data and control inputs registered before the array.
// - Separate read/write clocks may give unknown same-address read data.
`ifndef BRPC_REGS_VH
`define BRPC_REGS_VH

// ==========================================================================
// Geometry
`define BRPC_DATA_BITS   8192
`define BRPC_TOTAL_BITS  9216
`define BRPC_DEPTH       256
`define BRPC_IDX_W       8
`define BRPC_ADDR_W      10
`define BRPC_WORD_W      36
`define BRPC_LANE_W      9
`define BRPC_LANES       4
`define BRPC_PACK_BIT    7

// ==========================================================================
// Port width codes
`define BRPC_W9          2'h0
`define BRPC_W18         2'h1
`define BRPC_W36         2'h2

// ==========================================================================
// Reset values
`define BRPC_RST_WIDTH   2'h2
`define BRPC_RST_PACKED  1'h0
`define BRPC_RST_OREG    1'h0
`define BRPC_RST_NEWDATA 1'h0
`define BRPC_RST_ADDR    10'h000
`define BRPC_RST_WORD    36'h0_0000_0000
`define BRPC_RST_MASK    4'hf

// ==========================================================================
// Read latency in clocks after the registered address
`define BRPC_LAT_FLOW    1
`define BRPC_LAT_OREG    2

`endif

// File: test/brpc_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "brpc_regs.vh"
module brpc_top_sva (
    input wire logic                    clk,
    input wire logic                    sys_rst,
    input wire logic                    chip_wide_clear_n,
    input wire logic                    cfg_oreg_a,
    input wire logic                    cfg_oreg_b,
    input wire logic                    a_in_ce,
    input wire logic                    a_aclr,
    input wire logic                    a_rden,
    input wire logic [`BRPC_WORD_W-1:0] a_dout,
    input wire logic                    b_aclr,
    input wire logic                    b_out_ce,
    input wire logic                    b_rden,
    input wire logic [`BRPC_WORD_W-1:0] b_dout
);
    // ======================================================================
    // Helpers
    wire logic quiet_a;
    // Flow mode, no clear active: only a read may move the output
    assign quiet_a = chip_wide_clear_n && !a_aclr && !cfg_oreg_a;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ======================================================================
    // Assertions
    chk_a_aclr_zero: assert property (a_aclr |-> a_dout == '0)
        else $error("port a output not cleared");
    chk_b_aclr_zero: assert property (b_aclr |-> b_dout == '0)
        else $error("port b output not cleared");
    chk_chip_clear: assert property (
        !chip_wide_clear_n |-> a_dout == '0 && b_dout == '0)
        else $error("chip clear left output set");
    chk_reset_zero: assert property (
        $fell(sys_rst) |-> a_dout == '0 && b_dout == '0)
        else $error("output not zero after reset");
    chk_ce_gate: assert property (
        (!a_in_ce && quiet_a) ##1 quiet_a |-> $stable(a_dout))
        else $error("output moved with clock enable low");
    chk_rden_keep: assert property (
        (a_in_ce && !a_rden && quiet_a) ##1 quiet_a ##1 quiet_a
        |-> $stable(a_dout))
        else $error("output moved without read strobe");
    chk_read_latency: assert property (
        quiet_a ##1 (quiet_a && !$stable(a_dout))
        |-> $past(a_rden, 2) && $past(a_in_ce, 2) && $past(a_in_ce))
        else $error("flow output moved at wrong cycle");
    chk_oreg_b_ce: assert property (
        cfg_oreg_b && $past(cfg_oreg_b, 2) && !b_aclr
        && chip_wide_clear_n && !$stable(b_dout) |-> $past(b_out_ce))
        else $error("registered output moved without enable");
    cover property (a_aclr);
    cover property (!a_in_ce && quiet_a);
    cover property (cfg_oreg_b && b_out_ce && b_rden);
endmodule
bind brpc_top brpc_top_sva u_brpc_top_sva (.clk, .sys_rst,
    .chip_wide_clear_n, .cfg_oreg_a, .cfg_oreg_b, .a_in_ce, .a_aclr,
    .a_rden, .a_dout, .b_aclr, .b_out_ce, .b_rden, .b_dout);
`default_nettype wire

// File: test/brpc_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "brpc_regs.vh"
module brpc_top_tb_top;
    typedef struct {
        logic w; logic r; logic [9:0] ad;
        logic [35:0] d; logic [3:0] m; logic [35:0] e;
    } brpc_row_t;
    localparam logic [35:0] ones = 36'hf_ffff_ffff;
    localparam logic [35:0] da = 36'h1_2345_6789;
    localparam logic [35:0] db = 36'h9_8765_4321;
    logic clk = 1'h0, sys_rst = 1'h1, chip_wide_clear_n = 1'h1;
    logic [1:0] cfg_width_a = `BRPC_W36, cfg_width_b = `BRPC_W36;
    logic cfg_packed = 1'h0, cfg_new_data = 1'h0;
    logic cfg_oreg_a = 1'h0, cfg_oreg_b = 1'h0;
    logic a_in_ce, a_out_ce, a_aclr, a_hold, a_wren, a_rden;
    logic b_in_ce, b_out_ce, b_aclr, b_hold, b_wren, b_rden;
    logic [9:0] a_addr, b_addr;
    logic [35:0] a_din, b_din, a_dout, b_dout;
    logic [3:0] a_lane_mask, b_lane_mask;
    int miscompares = 0, total_checks = 0, cycles = 0;
    // Old-data mode, x36, flow output
    brpc_row_t rows [12] = '{
        '{1'h1, 1'h0, 10'h005, ones, 4'hf, 36'h0},
        '{1'h0, 1'h1, 10'h005, 36'h0, 4'hf, ones},
        '{1'h1, 1'h0, 10'h005, 36'h0, 4'h5, ones},
        '{1'h0, 1'h1, 10'h005, 36'h0, 4'hf, 36'hf_f803_fe00},
        '{1'h1, 1'h0, 10'h005, 36'h0, 4'ha, 36'hf_f803_fe00},
        '{1'h0, 1'h1, 10'h005, 36'h0, 4'hf, 36'h0},
        '{1'h1, 1'h0, 10'h009, 36'h8_0402_0100, 4'hf, 36'h0},
        '{1'h0, 1'h1, 10'h009, 36'h0, 4'hf, 36'h8_0402_0100},
        '{1'h1, 1'h0, 10'h005, ones, 4'h0, 36'h8_0402_0100},
        '{1'h0, 1'h1, 10'h005, 36'h0, 4'hf, 36'h0},
        '{1'h1, 1'h1, 10'h005, ones, 4'h3, 36'h0},
        '{1'h0, 1'h1, 10'h005, 36'h0, 4'hf, 36'h0_0003_ffff}};
    brpc_top u_brpc_top (.clk, .sys_rst, .chip_wide_clear_n,
        .cfg_width_a, .cfg_width_b, .cfg_packed, .cfg_new_data,
        .cfg_oreg_a, .cfg_oreg_b, .a_in_ce, .a_out_ce, .a_aclr, .a_hold,
        .a_addr, .a_din, .a_lane_mask, .a_wren, .a_rden, .a_dout,
        .b_in_ce, .b_out_ce, .b_aclr, .b_hold, .b_addr, .b_din,
        .b_lane_mask, .b_wren, .b_rden, .b_dout);
    brpc_user_port u_brpc_user_port (.clk, .in_ce(a_in_ce),
        .out_ce(a_out_ce), .hold(a_hold), .aclr(a_aclr), .addr(a_addr),
        .din(a_din), .lane_mask(a_lane_mask), .wren(a_wren), .rden(a_rden));
    brpc_user_port u_brpc_user_port_b (.clk, .in_ce(b_in_ce),
        .out_ce(b_out_ce), .hold(b_hold), .aclr(b_aclr), .addr(b_addr),
        .din(b_din), .lane_mask(b_lane_mask), .wren(b_wren), .rden(b_rden));
    // ======================================================================
    // Clock, timeout, checking
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic settle();
        @(posedge clk);
        #1;
    endtask
    task automatic both(input logic w, input logic [9:0] aa,
        input logic [35:0] ad, input logic [9:0] ba, input logic [35:0] bd);
        fork
            u_brpc_user_port.op(w, !w, aa, ad, 4'hf);
            u_brpc_user_port_b.op(w, !w, ba, bd, 4'hf);
        join
    endtask
    // ======================================================================
    // Sequence
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'h0;
        settle();
        check(a_dout, 36'h0);
        check(b_dout, 36'h0);
        for (int i = 0; i < 12; i++) begin
            u_brpc_user_port.op(rows[i].w, rows[i].r, rows[i].ad,
                                rows[i].d, rows[i].m);
            settle();
            check(a_dout, rows[i].e);
        end
        @(posedge clk) cfg_new_data <= 1'h1;
        u_brpc_user_port.op(1'h1, 1'h1, 10'h005, 36'h0, 4'h1);
        settle();
        check(a_dout, 36'h0_0003_fe00);
        @(posedge clk) u_brpc_user_port.in_ce <= 1'h0;
        u_brpc_user_port.op(1'h1, 1'h0, 10'h005, ones, 4'hf);
        @(posedge clk) u_brpc_user_port.in_ce <= 1'h1;
        u_brpc_user_port.op(1'h0, 1'h1, 10'h005, 36'h0, 4'hf);
        settle();
        check(a_dout, 36'h0_0003_fe00);
        @(posedge clk) u_brpc_user_port.hold <= 1'h1;
        u_brpc_user_port.op(1'h1, 1'h0, 10'h009, 36'h0, 4'hf);
        @(posedge clk) u_brpc_user_port.hold <= 1'h0;
        u_brpc_user_port.op(1'h0, 1'h1, 10'h005, 36'h0, 4'hf);
        settle();
        check(a_dout, 36'h0);
        u_brpc_user_port.op(1'h0, 1'h1, 10'h009, 36'h0, 4'hf);
        settle();
        check(a_dout, 36'h8_0402_0100);
        u_brpc_user_port.set_clr(1'h1);
        #1;
        check(a_dout, 36'h0);
        u_brpc_user_port.set_clr(1'h0);
        both(1'h1, 10'h014, da, 10'h015, db);
        both(1'h0, 10'h015, 36'h0, 10'h014, 36'h0);
        settle();
        check(a_dout, db);
        check(b_dout, da);
        @(posedge clk) cfg_oreg_b <= 1'h1;
        u_brpc_user_port_b.out_ce <= 1'h0;
        u_brpc_user_port_b.op(1'h0, 1'h1, 10'h015, 36'h0, 4'hf);
        settle();
        settle();
        check(b_dout, da);
        @(posedge clk) u_brpc_user_port_b.out_ce <= 1'h1;
        settle();
        check(b_dout, db);
        u_brpc_user_port_b.op(1'h0, 1'h1, 10'h014, 36'h0, 4'hf);
        settle();
        check(b_dout, db);
        settle();
        check(b_dout, da);
        @(posedge clk) chip_wide_clear_n <= 1'h0;
        #1;
        check(a_dout, 36'h0);
        check(b_dout, 36'h0);
        @(posedge clk) chip_wide_clear_n <= 1'h1;
        cfg_packed <= 1'h1;
        cfg_width_a <= `BRPC_W18;
        cfg_width_b <= `BRPC_W18;
        cfg_oreg_b <= 1'h0;
        settle();
        both(1'h1, 10'h000, 36'h0_0001_1111, 10'h000, 36'h0_0002_2222);
        both(1'h0, 10'h000, 36'h0, 10'h000, 36'h0);
        settle();
        check(a_dout, 36'h0_0001_1111);
        check(b_dout, 36'h0_0002_2222);
        end_of_test();
    end
endmodule
`default_nettype wire

// File: test/brpc_user_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "brpc_regs.vh"
module brpc_user_port (
    input  wire logic                    clk,
    output var  logic                    in_ce = 1'h1,
    output var  logic                    out_ce = 1'h1,
    output var  logic                    hold = 1'h0,
    output var  logic                    aclr = 1'h0,
    output var  logic [`BRPC_ADDR_W-1:0] addr = '0,
    output var  logic [`BRPC_WORD_W-1:0] din = '0,
    output var  logic [`BRPC_LANES-1:0]  lane_mask = 4'hf,
    output var  logic                    wren = 1'h0,
    output var  logic                    rden = 1'h0
);
    task automatic op(input logic w, input logic r,
                      input logic [`BRPC_ADDR_W-1:0] a,
                      input logic [`BRPC_WORD_W-1:0] d,
                      input logic [`BRPC_LANES-1:0] m);
        @(posedge clk);
        wren <= w;
        rden <= r;
        addr <= a;
        din <= d;
        lane_mask <= m;
        @(posedge clk);
        wren <= 1'h0;
        rden <= 1'h0;
        // Released bus shows inverse so stale data never matches
        din <= ~d;
    endtask
    task automatic set_clr(input logic v);
        @(posedge clk);
        while (rden) @(posedge clk);
        aclr <= v;
    endtask
endmodule
`default_nettype wire
